// ---- hdl/pee_host.sv ----
// host controller for a self-timed parallel eeprom
`timescale 1ns/1ps
`default_nettype none
module pee_host #(
  parameter int unsigned WRITE_TIME_CYC = pee_pkg::WRITE_TIME_CYC,
  parameter int unsigned LOAD_MAX_CYC = pee_pkg::LOAD_MAX_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // user request
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic req_last,
  input wire logic req_poll_en,
  input wire logic [pee_pkg::ADDR_W-1:0] req_addr,
  input wire logic [pee_pkg::DATA_W-1:0] req_wdata,
  // user answer
  output logic rsp_valid,
  output logic [pee_pkg::DATA_W-1:0] rsp_rdata,
  output logic rsp_timeout,
  output logic busy,
  // memory pins
  output logic mem_sel_n,
  output logic mem_oe_n,
  output logic mem_we_n,
  output logic [pee_pkg::ADDR_W-1:0] mem_addr,
  input wire logic [pee_pkg::DATA_W-1:0] mem_dq_i,
  output logic [pee_pkg::DATA_W-1:0] mem_dq_o,
  output logic mem_dq_oe
);
  typedef enum logic [3:0] {
    ST_IDLE, ST_RD, ST_RD_REL, ST_WR_SETUP, ST_WR_PULSE, ST_WR_HOLD,
    ST_LOAD_GAP, ST_POLL_RD, ST_POLL_REL, ST_NEXT_GAP
  } pee_state_e;

  localparam logic [pee_pkg::CNT_W-1:0] C_READ = pee_pkg::CNT_W'(pee_pkg::READ_CYC);
  localparam logic [pee_pkg::CNT_W-1:0] C_WP = pee_pkg::CNT_W'(pee_pkg::WPULSE_CYC);
  localparam logic [pee_pkg::CNT_W-1:0] C_REL = pee_pkg::CNT_W'(pee_pkg::RELEASE_CYC);
  localparam logic [pee_pkg::CNT_W-1:0] C_LMIN = pee_pkg::CNT_W'(pee_pkg::LOAD_MIN_CYC);
  localparam logic [pee_pkg::CNT_W-1:0] C_LMAX = pee_pkg::CNT_W'(LOAD_MAX_CYC);
  localparam logic [pee_pkg::CNT_W-1:0] C_NEXT = pee_pkg::CNT_W'(pee_pkg::NEXT_WRITE_CYC);
  localparam logic [pee_pkg::CNT_W-1:0] C_WT = pee_pkg::CNT_W'(WRITE_TIME_CYC);

  function automatic logic [pee_pkg::CNT_W-1:0] inc(input logic [pee_pkg::CNT_W-1:0] v);
    inc = v + pee_pkg::CNT_W'(1);
  endfunction

  pee_state_e st_q, st_d;
  logic [pee_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic [pee_pkg::CNT_W-1:0] wt_q, wt_d;
  logic sel_q, sel_d, oe_q, oe_d, we_q, we_d, dqoe_q, dqoe_d;
  logic [pee_pkg::ADDR_W-1:0] addr_q, addr_d;
  logic [pee_pkg::DATA_W-1:0] wdat_q, wdat_d, rdat_q, rdat_d, prev_q, prev_d;
  logic poll_q, poll_d, last_q, last_d, havep_q, havep_d;
  logic rv_q, rv_d, to_q, to_d;
  logic [pee_pkg::DATA_W-1:0] dq_s;

  pee_sync #(.W(pee_pkg::DATA_W)) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .din(mem_dq_i),
    .dout(dq_s)
  );

  // a new byte is only taken where the page timing allows it
  assign req_ready = (st_q == ST_IDLE) || (st_q == ST_LOAD_GAP && cnt_q >= C_LMIN && req_write);

  always_comb
  begin
    st_d = st_q;
    cnt_d = inc(cnt_q);
    wt_d = wt_q;
    sel_d = sel_q;
    oe_d = oe_q;
    we_d = we_q;
    dqoe_d = dqoe_q;
    addr_d = addr_q;
    wdat_d = wdat_q;
    rdat_d = rdat_q;
    prev_d = prev_q;
    poll_d = poll_q;
    last_d = last_q;
    havep_d = havep_q;
    rv_d = 1'b0;
    to_d = 1'b0;
    case (st_q)
      ST_IDLE:
      begin
        if (req_valid)
        begin
          addr_d = req_addr;
          wdat_d = req_wdata;
          cnt_d = '0;
          sel_d = 1'b0;
          if (req_write)
          begin
            // write: select low, output enable high
            oe_d = 1'b1; // R8
            dqoe_d = 1'b1;
            poll_d = req_poll_en;
            last_d = req_last;
            st_d = ST_WR_SETUP;
          end
          else
          begin
            oe_d = 1'b0; // R8
            st_d = ST_RD;
          end
        end
      end
      ST_RD:
      begin
        if (cnt_q >= C_READ)
        begin
          rdat_d = dq_s;
          sel_d = 1'b1;
          oe_d = 1'b1;
          cnt_d = '0;
          st_d = ST_RD_REL;
        end
      end
      ST_RD_REL:
      begin
        // bus is not reused until the part lets go
        if (cnt_q >= C_REL) // R7
        begin
          rv_d = 1'b1;
          st_d = ST_IDLE;
        end
      end
      ST_WR_SETUP:
      begin
        // data and address settle a pulse width before strobe
        if (cnt_q >= C_WP)
        begin
          we_d = 1'b0;
          cnt_d = '0;
          st_d = ST_WR_PULSE;
        end
      end
      ST_WR_PULSE:
      begin
        if (cnt_q >= C_WP)
        begin
          we_d = 1'b1;
          cnt_d = '0;
          st_d = ST_WR_HOLD;
        end
      end
      ST_WR_HOLD:
      begin
        if (cnt_q >= C_WP)
        begin
          sel_d = 1'b1;
          dqoe_d = 1'b0;
          cnt_d = '0;
          wt_d = '0;
          havep_d = 1'b0;
          rv_d = 1'b1;
          st_d = last_q ? (poll_q ? ST_POLL_RD : ST_NEXT_GAP) : ST_LOAD_GAP;
          if (last_q && poll_q)
          begin
            sel_d = 1'b0;
            oe_d = 1'b0; // R4
          end
        end
      end
      ST_LOAD_GAP:
      begin
        // next load must start before the window closes
        if (req_valid && req_ready) // R3
        begin
          addr_d = req_addr;
          wdat_d = req_wdata;
          last_d = req_last;
          sel_d = 1'b0;
          dqoe_d = 1'b1;
          cnt_d = '0;
          st_d = ST_WR_SETUP;
        end
        else if (cnt_q >= C_LMAX) // R3
        begin
          // late source: page closes, device starts writing
          cnt_d = '0;
          wt_d = '0;
          st_d = poll_q ? ST_POLL_RD : ST_NEXT_GAP;
          sel_d = ~poll_q;
          oe_d = ~poll_q;
        end
      end
      ST_POLL_RD:
      begin
        wt_d = inc(wt_q);
        // polling is a full read cycle
        if (cnt_q >= C_READ) // R5
        begin
          prev_d = dq_s;
          havep_d = 1'b1;
          sel_d = 1'b1;
          oe_d = 1'b1;
          cnt_d = '0;
          st_d = ST_POLL_REL;
        end
      end
      ST_POLL_REL:
      begin
        wt_d = inc(wt_q);
        if (cnt_q >= C_REL) // R7
        begin
          cnt_d = '0;
          // toggle bit stopped: write is done
          if (havep_q && prev_q[pee_pkg::TOGGLE_BIT] == rdat_q[pee_pkg::TOGGLE_BIT]
              && wt_q > C_READ + C_READ) // R9
          begin
            wt_d = '0;
            st_d = ST_NEXT_GAP;
          end
          else if (wt_q >= C_WT) // R1 R2 R9
          begin
            to_d = 1'b1;
            st_d = ST_NEXT_GAP;
          end
          else
          begin
            rdat_d = prev_q;
            sel_d = 1'b0;
            oe_d = 1'b0;
            st_d = ST_POLL_RD;
          end
        end
      end
      ST_NEXT_GAP:
      begin
        // without polling sit out the whole write, then the gap
        wt_d = inc(wt_q);
        if ((poll_q || wt_q >= C_WT) && cnt_q >= C_NEXT) // R1 R6
        begin
          st_d = ST_IDLE;
        end
        else if (!poll_q && wt_q < C_WT)
        begin
          cnt_d = '0;
        end
      end
      default:
      begin
        st_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      st_q <= ST_IDLE;
      cnt_q <= '0;
      wt_q <= '0;
      sel_q <= 1'b1;
      oe_q <= 1'b1;
      we_q <= 1'b1;
      dqoe_q <= 1'b0;
      addr_q <= '0;
      wdat_q <= '0;
      rdat_q <= '0;
      prev_q <= '0;
      poll_q <= 1'b0;
      last_q <= 1'b0;
      havep_q <= 1'b0;
      rv_q <= 1'b0;
      to_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      wt_q <= wt_d;
      sel_q <= sel_d;
      oe_q <= oe_d;
      we_q <= we_d;
      dqoe_q <= dqoe_d;
      addr_q <= addr_d;
      wdat_q <= wdat_d;
      rdat_q <= rdat_d;
      prev_q <= prev_d;
      poll_q <= poll_d;
      last_q <= last_d;
      havep_q <= havep_d;
      rv_q <= rv_d;
      to_q <= to_d;
    end
  end

  assign mem_sel_n = sel_q;
  assign mem_oe_n = oe_q;
  assign mem_we_n = we_q;
  assign mem_addr = addr_q;
  assign mem_dq_o = wdat_q;
  assign mem_dq_oe = dqoe_q;
  assign rsp_valid = rv_q;
  assign rsp_rdata = rdat_q;
  assign rsp_timeout = to_q;
  assign busy = (st_q != ST_IDLE);
endmodule
`default_nettype wire

// ---- inc/pee_pkg.sv ----
// constants for the parallel eeprom host controller
// Behaviour
// R1: wait full write time unless polling
// R2: device self-completes write within five ms
// R3: byte loads spaced 0.15 to 100 us
// R4: output enable pulse between loads polls
// R5: polling access is ordinary read cycle
// R6: ten us before next write operation
// R7: device releases bus within 30 ns
// R8: select/oe/strobe levels choose read or write
// R9: finish only on poll result, else timeout
package pee_pkg;
  localparam int unsigned CLK_MHZ = 40;
  localparam int unsigned CLK_NS = 25;
  localparam int unsigned ADDR_W = 13;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PAGE_BYTES = 64;
  // read and write strobe timing, ns
  localparam int unsigned READ_CYCLE_NS = 120;
  localparam int unsigned WRITE_PULSE_NS = 50;
  localparam int unsigned DATA_SETUP_NS = 50;
  localparam int unsigned ADDR_HOLD_NS = 50;
  localparam int unsigned RELEASE_NS = 30;
  // long waits
  localparam int unsigned INTERNAL_WRITE_TIME_MS = 5;
  localparam int unsigned BYTE_LOAD_INTERVAL_MIN_NS = 150;
  localparam int unsigned BYTE_LOAD_INTERVAL_MAX_US = 100;
  localparam int unsigned NEXT_WRITE_DELAY_US = 10;
  // cycle counts: least times round up, longest round down
  localparam int unsigned READ_CYC = (READ_CYCLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned WPULSE_CYC = (WRITE_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned RELEASE_CYC = (RELEASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned LOAD_MIN_CYC = (BYTE_LOAD_INTERVAL_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned LOAD_MAX_CYC = BYTE_LOAD_INTERVAL_MAX_US * CLK_MHZ;
  localparam int unsigned NEXT_WRITE_CYC = NEXT_WRITE_DELAY_US * CLK_MHZ;
  localparam int unsigned WRITE_TIME_CYC = INTERNAL_WRITE_TIME_MS * 1000 * CLK_MHZ;
  localparam int unsigned CNT_W = 24;
  localparam int unsigned TOGGLE_BIT = 6;
endpackage

// ---- hdl/pee_sync.sv ----
// two-flop synchroniser for the data pins
`timescale 1ns/1ps
`default_nettype none
module pee_sync #(
  parameter int unsigned W = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb
  begin
    meta_d = din;
    sync_d = meta_q;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign dout = sync_q;
endmodule
`default_nettype wire

// ---- testbench/pee_host_sva.sv ----
// pin and answer checker for the eeprom host
`timescale 1ns/1ps
`default_nettype none
module pee_host_sva (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // user side
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic req_write,
  input wire logic rsp_valid,
  input wire logic rsp_timeout,
  // pins
  input wire logic mem_sel_n,
  input wire logic mem_oe_n,
  input wire logic mem_we_n,
  input wire logic mem_dq_oe
);
  // ----
  // assertions
  // ----
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  a_rw_clash: assert property (mem_oe_n || mem_we_n)
    else $error("both strobes low");
  a_oe_no_drive: assert property (!mem_oe_n |-> !mem_dq_oe)
    else $error("bus driven in read");
  a_we_selected: assert property (!mem_we_n |-> !mem_sel_n && mem_dq_oe)
    else $error("strobe without select or data");
  a_we_pulse: assert property ($fell(mem_we_n) |-> !mem_we_n [*2])
    else $error("write pulse short");
  a_load_gap: assert property ($rose(mem_we_n) |-> mem_we_n [*6])
    else $error("byte loads too close");
  a_read_len: assert property ($fell(mem_oe_n) |-> !mem_oe_n [*5])
    else $error("read cycle short");
  a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
    else $error("answer longer than one cycle");
  a_rd_answer: assert property (req_valid && req_ready && !req_write |-> ##10 rsp_valid)
    else $error("read answer late");
  a_wr_answer: assert property (req_valid && req_ready && req_write |-> ##10 rsp_valid)
    else $error("load answer late");
  c_read: cover property (req_valid && req_ready && !req_write);
  c_write: cover property (req_valid && req_ready && req_write);
  c_timeout: cover property (rsp_timeout);
endmodule
bind pee_host pee_host_sva u_sva (.core_clk, .rst, .req_valid, .req_ready, .req_write, .rsp_valid,
  .rsp_timeout, .mem_sel_n, .mem_oe_n, .mem_we_n, .mem_dq_oe);
`default_nettype wire

// ---- testbench/pee_dev.sv ----
// behavioural self-timed eeprom at the host pins
`timescale 1ns/1ps
`default_nettype none
module pee_dev (
  // clock
  input wire logic core_clk,
  // pins
  input wire logic sel_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [pee_pkg::ADDR_W-1:0] addr,
  input wire logic [7:0] dq_o,
  input wire logic dq_oe,
  output logic [7:0] dq
);
  logic [7:0] mem [0:8191];
  logic [7:0] rd;
  logic [7:0] lst = 8'h00;
  logic tog = 1'b0;
  logic pdrv = 1'b0;
  logic drv;
  int cnt = 0;
  int wt = 60;
  assign drv = !sel_n && !oe_n && we_n;
  // busy reads show a toggling bit so polling can see the end
  assign rd = (cnt != 0) ? {mem[addr][7], tog, mem[addr][5:0]} : mem[addr];
  // released bus shows the inverse, so a stale value never matches
  assign dq = dq_oe ? dq_o : (drv ? rd : ~lst);
  always @(posedge core_clk)
  begin
    pdrv <= drv;
    if (drv)
      lst <= rd;
    if (pdrv && !drv && cnt != 0)
      tog <= ~tog;
    if (!sel_n && !we_n && oe_n)
    begin
      mem[addr] <= dq_o;
      cnt <= wt;
    end
    else if (cnt != 0)
      cnt <= cnt - 1;
  end
endmodule
`default_nettype wire

// ---- testbench/pee_host_tb.sv ----
// testbench for the eeprom host controller
`timescale 1ns/1ps
`default_nettype none
module pee_host_tb;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0, req_write = 1'b0, req_last = 1'b0, req_poll_en = 1'b0;
  logic [12:0] req_addr = 13'h0000;
  logic [7:0] req_wdata = 8'h00;
  logic req_ready, rsp_valid, rsp_timeout, busy, mem_sel_n, mem_oe_n, mem_we_n, mem_dq_oe;
  logic [7:0] rsp_rdata, mem_dq_o, dq;
  logic [12:0] mem_addr;
  int errors = 0;
  int n_compared = 0;
  always #12.5 core_clk = ~core_clk;
  // short write time keeps the run small
  pee_host #(.WRITE_TIME_CYC(500), .LOAD_MAX_CYC(100)) DUT (.core_clk, .rst, .req_valid, .req_ready,
    .req_write, .req_last, .req_poll_en, .req_addr, .req_wdata, .rsp_valid, .rsp_rdata, .rsp_timeout,
    .busy, .mem_sel_n, .mem_oe_n, .mem_we_n, .mem_addr, .mem_dq_i(dq), .mem_dq_o, .mem_dq_oe);
  pee_dev dev (.core_clk, .sel_n(mem_sel_n), .oe_n(mem_oe_n), .we_n(mem_we_n), .addr(mem_addr),
    .dq_o(mem_dq_o), .dq_oe(mem_dq_oe), .dq(dq));
  // ----
  // helpers
  // ----
  task automatic tally_and_finish;
    if (errors == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wait_for(ref logic f, input logic lvl, input int n, output int k);
    k = 0;
    while (f !== lvl && k < n)
    begin
      @(posedge core_clk);
      #1;
      k++;
    end
    if (k >= n)
    begin
      errors++;
      $display("BAD %0t wait ran out", $time);
      tally_and_finish();
    end
  endtask
  task automatic req(input logic w, l, p, input logic [12:0] a, input logic [7:0] d);
    int k;
    req_write = w;
    req_last = l;
    req_poll_en = p;
    req_addr = a;
    req_wdata = d;
    req_valid = 1'b1;
    wait_for(req_ready, 1'b1, 5000, k);
    @(posedge core_clk);
    #1;
    req_valid = 1'b0;
    wait_for(rsp_valid, 1'b1, 20, k);
    // setup, pulse and hold each last one cycle past their width
    if (w)
      chk(8'(k), 8'(3 * (pee_pkg::WPULSE_CYC + 1)));
    else
      chk(8'(k), 8'(pee_pkg::READ_CYC + pee_pkg::RELEASE_CYC + 2));
  endtask
  task automatic rd_chk(input logic [12:0] a, input logic [7:0] exp);
    req(1'b0, 1'b0, 1'b0, a, 8'h00);
    chk(rsp_rdata, exp);
  endtask
  // ----
  // scenarios
  // ----
  task automatic sc_reset;
    chk({2'h0, mem_sel_n, mem_oe_n, mem_we_n, mem_dq_oe, req_ready, busy}, 8'h3a);
  endtask
  task automatic sc_poll;
    int k;
    req(1'b1, 1'b1, 1'b1, 13'h0005, 8'h5a);
    wait_for(busy, 1'b0, 2000, k);
    chk({7'h00, k < 850}, 8'h01);
    rd_chk(13'h0005, 8'h5a);
  endtask
  task automatic sc_page;
    int k;
    req(1'b1, 1'b0, 1'b0, 13'h0010, 8'ha5);
    req(1'b1, 1'b1, 1'b0, 13'h0011, 8'h3c);
    wait_for(busy, 1'b0, 2000, k);
    chk({7'h00, k >= 850}, 8'h01);
    rd_chk(13'h0010, 8'ha5);
    rd_chk(13'h0011, 8'h3c);
  endtask
  task automatic sc_late;
    int k;
    // no closing byte: the page shuts itself when the load window runs out
    req(1'b1, 1'b0, 1'b1, 13'h0030, 8'h96);
    wait_for(busy, 1'b0, 2000, k);
    chk({7'h00, k > 100}, 8'h01);
    rd_chk(13'h0030, 8'h96);
  endtask
  task automatic sc_timeout;
    int k;
    // device slower than the limit: polling must give up
    dev.wt = 3000;
    req(1'b1, 1'b1, 1'b1, 13'h0020, 8'hc3);
    wait_for(rsp_timeout, 1'b1, 700, k);
    wait_for(busy, 1'b0, 2000, k);
    chk({7'h00, k >= pee_pkg::NEXT_WRITE_CYC}, 8'h01);
  endtask
  initial
  begin
    repeat (2) @(posedge core_clk);
    #1;
    rst = 1'b0;
    @(posedge core_clk);
    #1;
    sc_reset();
    sc_poll();
    sc_page();
    sc_late();
    sc_timeout();
    tally_and_finish();
  end
endmodule
`default_nettype wire
